// ---- hw/adc_calibration_correction.sv ----
// calibration sequencer and result correction of the converter
// assumes the modulator answers conv_req with one raw_valid pulse later
`timescale 1ns/1ns
module adc_calibration_correction
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  // register port
  input  wire logic [adc_cal_pkg::AW-1:0] reg_addr,
  input  wire logic [adc_cal_pkg::DW-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [adc_cal_pkg::DW-1:0] reg_rdata,
  // modulator side
  input  wire logic [adc_cal_pkg::DW-1:0] raw_data,
  input  wire logic                     raw_valid,
  output logic                          conv_req,
  output logic      [1:0]               cal_input_sel,
  output logic      [1:0]               line_filter_select,
  output logic      [3:0]               rate_select,
  output logic      [2:0]               gain_select,
  output logic                          cal_busy
);
  import adc_cal_pkg::*;

  typedef struct packed {
    cal_state_t       st;
    logic [2:0]       cmd;
    logic [1:0]       line;
    logic [3:0]       rate;
    logic [2:0]       gsel;
    logic [1:0]       yset;
    logic [3:0]       slot;
    logic [23:0]      soff;
    logic [7:0][23:0] sgain;
    logic [23:0]      yoff_a;
    logic [23:0]      ygai_a;
    logic [23:0]      yoff_b;
    logic [23:0]      ygai_b;
    logic [7:0][23:0] res;
    logic [29:0]      den;
    logic [30:0]      rem;
    logic [23:0]      quo;
    logic [4:0]       cnt;
    logic             req;
    logic [1:0]       insel;
    logic [23:0]      rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // ---------------------------------------------------------------
  // arithmetic helpers
  // ---------------------------------------------------------------
  // clamp to a signed 24-bit code; wrapping would flip the sign
  function automatic logic [23:0] sat24(input logic signed [29:0] x);
    if (x > $signed({6'h00, OMAX}))
      return OMAX;
    else if (x < $signed({6'h3F, OMIN}))
      return OMIN;
    else
      return x[23:0];
  endfunction : sat24

  // raw in quarter-code units minus offset, times internal gain
  function automatic logic signed [29:0] stage1(
    input logic [23:0] raw,
    input logic [23:0] off,
    input logic [23:0] g
  );
    logic signed [26:0] v;
    logic signed [51:0] p;
    v = $signed({raw[23], raw, 2'b00}) - $signed({{3{off[23]}}, off});
    p = v * $signed({1'b0, g});
    // shift the signed product so negative values keep their sign
    return 30'(p >>> 23);
  endfunction : stage1

  // subtract system offset; result stays in quarter-code units
  function automatic logic signed [29:0] stage2(
    input logic signed [29:0] m,
    input logic [23:0]        yoff
  );
    return m - $signed({{6{yoff[23]}}, yoff});
  endfunction : stage2

  // apply system gain and drop back to whole codes
  function automatic logic [23:0] stage3(
    input logic signed [29:0] n,
    input logic [23:0]        yg
  );
    logic signed [54:0] q;
    q = n * $signed({1'b0, yg});
    return sat24(q[54:25]);
  endfunction : stage3

  // ---------------------------------------------------------------
  // selected coefficients
  // ---------------------------------------------------------------
  logic [23:0]        use_yoff;
  logic [23:0]        use_ygai;
  logic signed [29:0] m1;
  logic signed [29:0] m2;
  logic [23:0]        corr;

  // set 3 is unused and behaves as no system correction
  always_comb
  begin
    use_yoff = OZERO;
    use_ygai = UNITY;
    if (s_reg.yset == SET_A)
    begin
      use_yoff = s_reg.yoff_a;
      use_ygai = s_reg.ygai_a;
    end
    else if (s_reg.yset == SET_B)
    begin
      use_yoff = s_reg.yoff_b;
      use_ygai = s_reg.ygai_b;
    end
    if (s_reg.cmd == CMD_YGAI_B || s_reg.cmd == CMD_YOFF_B)
      if (s_reg.st != ST_IDLE)
        use_yoff = s_reg.yoff_b;
    if (s_reg.cmd == CMD_YGAI_A || s_reg.cmd == CMD_YOFF_A)
      if (s_reg.st != ST_IDLE)
        use_yoff = s_reg.yoff_a;
  end

  // gain of the currently selected amplifier setting
  assign m1 = stage1(raw_data, s_reg.soff, s_reg.sgain[s_reg.gsel]);
  assign m2 = stage2(m1, use_yoff);
  assign corr = stage3(m2, use_ygai);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic        self_kind;
  logic [29:0] d_raw;
  logic [23:0] gain_fin;
  logic [23:0] q_last;

  assign self_kind = (s_reg.cmd == CMD_SELF) || (s_reg.cmd == CMD_PGA);
  // self kinds measure before gain; system gain after system offset
  assign d_raw = self_kind
    ? stage1(raw_data, s_reg.soff, UNITY)
    : m2;

  always_comb
  begin
    s_next = s_reg;
    s_next.req = 1'b0;
    s_next.rdata = '0;
    // register reads, answered one cycle later
    if (reg_rd)
    begin
      case (reg_addr)
        A_FILTER: s_next.rdata = {18'h0, s_reg.line, s_reg.rate};
        A_GAIN:   s_next.rdata = {21'h0, s_reg.gsel};
        A_SYSC:   s_next.rdata = {22'h0, s_reg.yset};
        A_RESULT_SLOT_SELECT:   s_next.rdata = {20'h0, s_reg.slot};
        A_CALCMD: s_next.rdata = {21'h0, s_reg.cmd};
        A_STATUS: s_next.rdata = {22'h0, s_reg.st};
        A_SOFF:   s_next.rdata = s_reg.soff;
        A_YOFF_A: s_next.rdata = s_reg.yoff_a;
        A_YGAI_A: s_next.rdata = s_reg.ygai_a;
        A_YOFF_B: s_next.rdata = s_reg.yoff_b;
        A_YGAI_B: s_next.rdata = s_reg.ygai_b;
        default:
        begin
          if (reg_addr[7:3] == A_SGAIN5)
            s_next.rdata = s_reg.sgain[reg_addr[2:0]];
          else if (reg_addr[7:3] == A_DATA5)
            s_next.rdata = s_reg.res[reg_addr[2:0]];
        end
      endcase
    end
    // host writes fill coefficients directly
    if (reg_wr)
    begin
      case (reg_addr)
        A_FILTER:
        begin
          s_next.line = reg_wdata[F_LINE+1:F_LINE];
          s_next.rate = reg_wdata[F_RATE+3:F_RATE];
        end
        A_GAIN:   s_next.gsel = reg_wdata[2:0];
        A_SYSC:   s_next.yset = reg_wdata[1:0];
        A_RESULT_SLOT_SELECT:   s_next.slot = reg_wdata[3:0];
        A_SOFF:   s_next.soff = reg_wdata;
        A_YOFF_A: s_next.yoff_a = reg_wdata;
        A_YGAI_A: s_next.ygai_a = reg_wdata;
        A_YOFF_B: s_next.yoff_b = reg_wdata;
        A_YGAI_B: s_next.ygai_b = reg_wdata;
        A_CALCMD:
        begin
          // a command while busy is dropped
          if (s_reg.st == ST_IDLE && reg_wdata[2:0] <= CMD_YGAI_B)
          begin
            s_next.cmd = reg_wdata[2:0];
            s_next.req = 1'b1;
            case (reg_wdata[2:0])
              CMD_SELF:
              begin
                s_next.st = ST_ZERO;
                s_next.insel = IN_ZERO;
              end
              CMD_PGA:
              begin
                s_next.st = ST_FULL;
                s_next.insel = IN_FULL;
              end
              CMD_YOFF_A, CMD_YOFF_B:
              begin
                s_next.st = ST_ZERO;
                s_next.insel = IN_EXT;
              end
              default:
              begin
                s_next.st = ST_FULL;
                s_next.insel = IN_EXT;
              end
            endcase
          end
        end
        default:
        begin
          if (reg_addr[7:3] == A_SGAIN5)
            s_next.sgain[reg_addr[2:0]] = reg_wdata;
        end
      endcase
    end
    // calibration sequence; its updates win over a host write
    case (s_reg.st)
      ST_IDLE:
      begin
        if (raw_valid && s_reg.slot < 4'(N_SLOT))
          s_next.res[s_reg.slot[2:0]] = corr;
      end
      ST_ZERO:
      begin
        if (raw_valid)
        begin
          if (s_reg.cmd == CMD_SELF)
          begin
            s_next.soff = sat24(30'($signed({raw_data, 2'b00})));
            s_next.st = ST_FULL;
            s_next.insel = IN_FULL;
            s_next.req = 1'b1;
          end
          else
          begin
            if (s_reg.cmd == CMD_YOFF_A)
              s_next.yoff_a = sat24(m1);
            else
              s_next.yoff_b = sat24(m1);
            s_next.st = ST_IDLE;
            s_next.insel = IN_EXT;
          end
        end
      end
      ST_FULL:
      begin
        if (raw_valid)
        begin
          s_next.st = ST_DIV;
          s_next.den = d_raw;
          s_next.rem = IDEAL;
          s_next.quo = '0;
          s_next.cnt = '0;
          // out of range: skip the divide and saturate
          if ($signed(d_raw) <= 0 || IDEAL >= {d_raw, 1'b0})
          begin
            s_next.quo = GMAX;
            s_next.cnt = DIV_LAST;
          end
        end
      end
      ST_DIV:
      begin
        // one quotient bit per cycle, msb first
        if (s_reg.quo != GMAX || s_reg.cnt != DIV_LAST)
        begin
          if (s_reg.rem >= {1'b0, s_reg.den})
          begin
            s_next.quo[5'd23 - s_reg.cnt] = 1'b1;
            s_next.rem = (s_reg.rem - {1'b0, s_reg.den}) << 1;
          end
          else
            s_next.rem = s_reg.rem << 1;
        end
        s_next.cnt = s_reg.cnt + 5'h01;
        if (s_reg.cnt == DIV_LAST)
        begin
          s_next.st = ST_IDLE;
          s_next.insel = IN_EXT;
          s_next.cnt = '0;
          case (s_reg.cmd)
            CMD_SELF: s_next.sgain[0] = gain_fin;
            CMD_PGA:  s_next.sgain[s_reg.gsel] = gain_fin;
            CMD_YGAI_A: s_next.ygai_a = gain_fin;
            default:  s_next.ygai_b = gain_fin;
          endcase
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------

  // last bit lands in this cycle; below one half is clamped up
  always_comb
  begin
    q_last = s_reg.quo;
    if (s_reg.quo != GMAX && s_reg.rem >= {1'b0, s_reg.den})
      q_last[0] = 1'b1;
    gain_fin = (q_last < HALF) ? HALF : q_last;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
      s_reg.soff <= OZERO;
      s_reg.sgain <= {N_GAIN{UNITY}};
      s_reg.ygai_a <= UNITY;
      s_reg.ygai_b <= UNITY;
    end
    else
      s_reg <= s_next;
  end

  assign reg_rdata = s_reg.rdata;
  assign conv_req = s_reg.req;
  assign cal_input_sel = s_reg.insel;
  assign line_filter_select = s_reg.line;
  assign rate_select = s_reg.rate;
  assign gain_select = s_reg.gsel;
  assign cal_busy = (s_reg.st != ST_IDLE);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_self_go;
    reg_wr && reg_addr == A_CALCMD && reg_wdata[2:0] == CMD_SELF
      && s_reg.st == ST_IDLE;
  endsequence
  sequence s_zero_done;
    s_reg.st == ST_ZERO && s_reg.cmd == CMD_SELF && raw_valid;
  endsequence

  AST_RST_COEFF: assert property (disable iff (1'b0)
    sys_rst |=> s_reg.soff == OZERO && s_reg.sgain[7] == UNITY)
    else $error("coefficients not at reset values");
  AST_SELF_START: assert property (s_self_go |=>
    s_reg.st == ST_ZERO && conv_req && cal_input_sel == IN_ZERO)
    else $error("self calibration did not start");
  AST_SELF_SECOND: assert property (s_zero_done |=>
    conv_req && cal_input_sel == IN_FULL ##1 !conv_req)
    else $error("second self conversion missing");
  AST_SELF_INT: assert property (cal_busy && s_reg.cmd == CMD_SELF
    |-> cal_input_sel != IN_EXT)
    else $error("self calibration on external pins");
  AST_DIV_END: assert property (
    s_reg.st == ST_DIV && s_reg.cnt == DIV_LAST |=> s_reg.st == ST_IDLE)
    else $error("divide length wrong");
  AST_GAIN_LOW: assert property (
    s_reg.st == ST_DIV && s_reg.cnt == DIV_LAST && s_reg.cmd == CMD_PGA
    |=> s_reg.sgain[$past(s_reg.gsel)] >= HALF)
    else $error("gain below one half");
  AST_PGA_ONLY: assert property (
    s_reg.st == ST_DIV && s_reg.cnt == DIV_LAST && s_reg.cmd == CMD_PGA
    && s_reg.gsel != 3'h0 && !reg_wr |=> $stable(s_reg.sgain[0]))
    else $error("wrong gain coefficient updated");
  AST_HOST_WR: assert property (
    reg_wr && reg_addr == A_SOFF && s_reg.st == ST_IDLE
    |=> s_reg.soff == $past(reg_wdata))
    else $error("host offset write lost");
  AST_RESULT: assert property (
    raw_valid && s_reg.st == ST_IDLE && s_reg.slot == 4'h2
    |=> s_reg.res[2] == $past(corr))
    else $error("result not stored in chosen slot");
  AST_NO_SYS: assert property (
    s_reg.yset == SET_NONE && s_reg.st == ST_IDLE
    |-> use_ygai == UNITY && use_yoff == OZERO)
    else $error("system set applied when none chosen");

endmodule : adc_calibration_correction

// ---- hw/adc_cal_pkg.sv ----
// constants for the converter calibration and result correction block
// assumes one 20 MHz clock and a 24-bit word register port
package adc_cal_pkg;

  // ---------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------
  localparam int DW       = 24;
  localparam int AW       = 8;
  localparam int N_GAIN   = 8;
  localparam int N_SLOT   = 8;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_FILTER = 8'h00;
  localparam logic [7:0] A_GAIN   = 8'h01;
  localparam logic [7:0] A_SYSC   = 8'h02;
  localparam logic [7:0] A_RESULT_SLOT_SELECT   = 8'h03;
  localparam logic [7:0] A_CALCMD = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h05;
  localparam logic [7:0] A_SOFF   = 8'h06;
  localparam logic [4:0] A_SGAIN5 = 5'h01;  // 0x08..0x0F, index in [2:0]
  localparam logic [7:0] A_YOFF_A = 8'h10;
  localparam logic [7:0] A_YGAI_A = 8'h11;
  localparam logic [7:0] A_YOFF_B = 8'h12;
  localparam logic [7:0] A_YGAI_B = 8'h13;
  localparam logic [4:0] A_DATA5  = 5'h03;  // 0x18..0x1F, index in [2:0]

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int F_RATE = 0;
  localparam int F_LINE = 4;

  // ---------------------------------------------------------------
  // coefficient codes and reset values
  // ---------------------------------------------------------------
  localparam logic [23:0] UNITY = 24'h800000;
  localparam logic [23:0] HALF  = 24'h400000;
  localparam logic [23:0] GMAX  = 24'hFFFFFF;
  localparam logic [23:0] OZERO = 24'h000000;
  localparam logic [23:0] OMAX  = 24'h7FFFFF;
  localparam logic [23:0] OMIN  = 24'h800000;
  // full-scale target in quarter-code units
  localparam logic [30:0] IDEAL = 31'h01FFFFFC;
  localparam logic [4:0]  DIV_LAST = 5'h17;

  // ---------------------------------------------------------------
  // commands, selections, states
  // ---------------------------------------------------------------
  localparam logic [2:0] CMD_SELF   = 3'h0;
  localparam logic [2:0] CMD_PGA    = 3'h1;
  localparam logic [2:0] CMD_YOFF_A = 3'h2;
  localparam logic [2:0] CMD_YGAI_A = 3'h3;
  localparam logic [2:0] CMD_YOFF_B = 3'h4;
  localparam logic [2:0] CMD_YGAI_B = 3'h5;
  localparam logic [1:0] SET_NONE = 2'h0;
  localparam logic [1:0] SET_A    = 2'h1;
  localparam logic [1:0] SET_B    = 2'h2;
  localparam logic [1:0] IN_EXT   = 2'h0;
  localparam logic [1:0] IN_ZERO  = 2'h1;
  localparam logic [1:0] IN_FULL  = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ZERO = 2'b01,
    ST_FULL = 2'b10,
    ST_DIV  = 2'b11
  } cal_state_t;

endpackage : adc_cal_pkg

// ---- tb/modulator_model.sv ----
// behavioural modulator facing the calibration block
// assumes one clock; answers each conv_req with one raw_valid pulse
`timescale 1ns/1ns
module modulator_model
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // block side
  input  wire logic        conv_req,
  input  wire logic [1:0]  cal_input_sel,
  output logic      [23:0] raw_data,
  output logic             raw_valid,
  // bench controls
  input  wire logic [7:0]  lat,
  input  wire logic        inj,
  input  wire logic [23:0] ext_level,
  input  wire logic [23:0] zero_level,
  input  wire logic [23:0] full_level
);
  logic       busy;
  logic [7:0] cnt;

  // ------------------------------------------------------------
  // conversion engine
  // ------------------------------------------------------------
  // data toggle outside a pulse so a stale word never looks valid
  always @(posedge sys_clk)
  begin
    raw_valid <= 1'b0;
    raw_data  <= ~raw_data;
    if (sys_rst)
      busy <= 1'b0;
    else if (inj)
    begin
      raw_valid <= 1'b1;
      raw_data  <= ext_level;
    end
    else if (conv_req)
    begin
      busy <= 1'b1;
      cnt  <= lat;
    end
    else if (busy && cnt != 8'h00)
      cnt <= cnt - 8'h01;
    else if (busy)
    begin
      busy      <= 1'b0;
      raw_valid <= 1'b1;
      // internal levels only when the block routes them
      case (cal_input_sel)
        2'h1:    raw_data <= zero_level;
        2'h2:    raw_data <= full_level;
        default: raw_data <= ext_level;
      endcase
    end
  end
endmodule : modulator_model

// ---- tb/tb.sv ----
// self-checking bench for the calibration and correction block
// assumes the modulator model and the design package are compiled first
`timescale 1ns/1ns
module tb;
  import adc_cal_pkg::*;
  logic        sys_clk, sys_rst, reg_wr, reg_rd, raw_valid, conv_req;
  logic        cal_busy, inj, rd_seen;
  logic [7:0]  reg_addr, lat;
  logic [23:0] reg_wdata, reg_rdata, raw_data;
  logic [23:0] ext_level, zero_level, full_level;
  logic [1:0]  cal_input_sel, line_filter_select;
  logic [3:0]  rate_select;
  logic [2:0]  gain_select, gsel;
  logic [23:0] exp_q[$];
  string       nm_q[$];
  int          n_mismatch, samples_checked, n_conv, cyc, seed;
  logic [23:0] soff, raw, sg[8], yoff[2], yg[2], dat[8];

  adc_calibration_correction i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_data(raw_data),
    .raw_valid(raw_valid), .conv_req(conv_req),
    .cal_input_sel(cal_input_sel), .line_filter_select(line_filter_select),
    .rate_select(rate_select), .gain_select(gain_select),
    .cal_busy(cal_busy));
  modulator_model i_mod (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .conv_req(conv_req), .cal_input_sel(cal_input_sel),
    .raw_data(raw_data), .raw_valid(raw_valid), .lat(lat), .inj(inj),
    .ext_level(ext_level), .zero_level(zero_level),
    .full_level(full_level));

  // ------------------------------------------------------------
  // clock, watchdog, conversion counter, read monitor
  // ------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    rd_seen <= reg_rd;
    if (conv_req === 1'b1)
      n_conv = n_conv + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end
  // read data stands only in the cycle after the strobe
  always @(negedge sys_clk)
    if (rd_seen === 1'b1)
      check(nm_q.pop_front(), reg_rdata, exp_q.pop_front());

  // ------------------------------------------------------------
  // shared tasks and reference arithmetic
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [23:0] seen,
                       input logic [23:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // one idle edge after each strobe keeps drives single per step
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [23:0] e,
                    input string nm);
    exp_q.push_back(e); nm_q.push_back(nm);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  task automatic conv(input logic [23:0] r);
    inj <= 1'b1; ext_level <= r;
    @(posedge sys_clk);
    inj <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : conv
  task automatic cal(input logic [2:0] cmd, input logic [1:0] isel,
                     input int nexp);
    int c0, i;
    c0 = n_conv; i = 0;
    wr(A_CALCMD, {21'h000000, cmd});
    @(negedge sys_clk);
    check("cal_busy", {23'h000000, cal_busy}, 24'h000001);
    check("input select", {22'h000000, cal_input_sel}, {22'h0, isel});
    @(posedge sys_clk);
    wr(A_CALCMD, 24'h000001);  // ignored while busy
    while (cal_busy !== 1'b0 && i < 3000)
    begin
      @(posedge sys_clk); i = i + 1;
    end
    check("cal done", {23'h0, cal_busy}, 24'h000000);
    check("conversions", 24'(n_conv - c0), 24'(nexp));
  endtask : cal
  function automatic longint sx(input logic [23:0] v);
    return longint'($signed(v));
  endfunction : sx
  function automatic logic [23:0] sat24(input longint x);
    if (x > 64'sh7FFFFF) return 24'h7FFFFF;
    if (x < -64'sh800000) return 24'h800000;
    return x[23:0];
  endfunction : sat24
  function automatic longint mval(input logic [23:0] r);
    return ((sx(r) * 4 - sx(soff)) * longint'(sg[gsel])) >>> 23;
  endfunction : mval
  // gain from a full-scale reading, clamped to one half .. under two
  // m is the measured level in quarter-code units
  function automatic logic [23:0] gcal(input longint m);
    longint q;
    if (m <= 0) return 24'hFFFFFF;
    q = (longint'(IDEAL) << 23) / m;
    if (q >= 64'h1000000) return 24'hFFFFFF;
    if (q < 64'h400000) return HALF;
    return q[23:0];
  endfunction : gcal
  function automatic logic [23:0] corr(input logic [23:0] r,
                                       input logic [1:0] s);
    logic [23:0] yo, yk;
    yo = (s == SET_A) ? yoff[0] : (s == SET_B) ? yoff[1] : OZERO;
    yk = (s == SET_A) ? yg[0] : (s == SET_B) ? yg[1] : UNITY;
    return sat24(((mval(r) - sx(yo)) * longint'(yk)) >>> 25);
  endfunction : corr
  function automatic logic [23:0] rgain();
    logic [23:0] v;
    v = $random(seed);
    return (v < HALF) ? (v | HALF) : v;
  endfunction : rgain

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 24'h000000; inj = 1'b0; lat = 8'h1E; ext_level = 24'h0;
    zero_level = 24'h000010; full_level = 24'h180000; seed = 32'h2577;
    n_mismatch = 0; samples_checked = 0; n_conv = 0; cyc = 0;
    soff = OZERO; yoff = '{OZERO, OZERO}; yg = '{UNITY, UNITY};
    for (int k = 0; k < 8; k++) begin sg[k] = UNITY; dat[k] = 24'h0; end
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    // reset values, unmapped and status reads
    rd(A_SOFF, OZERO, "self offset");
    for (int k = 0; k < 8; k++)
    begin
      rd({A_SGAIN5, 3'(k)}, UNITY, "self gain");
      rd({A_DATA5, 3'(k)}, 24'h000000, "result");
    end
    for (int k = 0; k < 4; k++)
      rd(A_YOFF_A + 8'(k), k[0] ? UNITY : OZERO, "system coeff");
    rd(A_STATUS, 24'h000000, "status");
    rd(8'h07, 24'h000000, "unmapped");
    $display("test reset done");
    // filter and rate reach the modulator; gain select is written to 0
    wr(A_FILTER, 24'h000025);
    wr(A_GAIN, 24'h000000);
    @(negedge sys_clk);
    check("line filter", {22'h0, line_filter_select}, 24'h000002);
    check("rate", {20'h0, rate_select}, 24'h000005);
    @(posedge sys_clk);
    rd(A_FILTER, 24'h000025, "filter reg");
    // self calibration with a slow modulator
    gsel = 3'h0;
    cal(CMD_SELF, IN_ZERO, 2);
    soff = sat24(sx(zero_level) * 4);
    sg[0] = gcal(sx(full_level) * 4 - sx(soff));
    rd(A_SOFF, soff, "self offset");
    rd({A_SGAIN5, 3'h0}, sg[0], "self gain 1");
    $display("test self cal done");
    // gain calibration at two gains: one saturates, one divides
    lat = 8'h01;
    for (int k = 0; k < 2; k++)
    begin
      gsel = k[0] ? 3'h7 : 3'h5;
      full_level = k[0] ? 24'h600000 : 24'h0C0000;
      wr(A_GAIN, {21'h0, gsel});
      @(negedge sys_clk);
      check("gain select", {21'h0, gain_select}, {21'h0, gsel});
      @(posedge sys_clk);
      cal(CMD_PGA, IN_FULL, 1);
      sg[gsel] = gcal(sx(full_level) * 4 - sx(soff));
      rd({A_SGAIN5, gsel}, sg[gsel], "selected gain");
      rd({A_SGAIN5, 3'h0}, sg[0], "gain 1 kept");
    end
    $display("test gain cal done");
    // system calibration: offset first, then full scale
    for (int k = 0; k < 2; k++)
    begin
      ext_level = $random(seed) & 24'h03FFFF;
      cal(k[0] ? CMD_YOFF_B : CMD_YOFF_A, IN_EXT, 1);
      yoff[k] = sat24(mval(ext_level));
      rd(k[0] ? A_YOFF_B : A_YOFF_A, yoff[k], "system offset");
      ext_level = 24'h600000;
      cal(k[0] ? CMD_YGAI_B : CMD_YGAI_A, IN_EXT, 1);
      yg[k] = gcal(mval(ext_level) - sx(yoff[k]));
      rd(k[0] ? A_YGAI_B : A_YGAI_A, yg[k], "system gain");
    end
    wr(A_CALCMD, 24'h000006);  // undefined code
    @(negedge sys_clk);
    check("busy on bad code", {23'h0, cal_busy}, 24'h000000);
    @(posedge sys_clk);
    $display("test system cal done");
    // host-written coefficients and every set selection
    for (int s = 0; s < 4; s++)
    begin
      gsel = $random(seed);
      soff = $random(seed);
      sg[gsel] = rgain();
      for (int k = 0; k < 2; k++)
      begin
        yoff[k] = $random(seed); yg[k] = rgain();
      end
      wr(A_GAIN, {21'h0, gsel});
      wr(A_SOFF, soff);
      wr({A_SGAIN5, gsel}, sg[gsel]);
      wr(A_YOFF_A, yoff[0]); wr(A_YGAI_A, yg[0]);
      wr(A_YOFF_B, yoff[1]); wr(A_YGAI_B, yg[1]);
      wr(A_SYSC, {22'h0, 2'(s)});
      rd({A_SGAIN5, gsel}, sg[gsel], "written gain");
      for (int k = 0; k < 2; k++)
      begin
        raw = $random(seed);
        wr(A_RESULT_SLOT_SELECT, 24'(2 * s + k));
        conv(raw);
        dat[2 * s + k] = corr(raw, 2'(s));
        rd({A_DATA5, 3'(2 * s + k)}, dat[2 * s + k], "result");
      end
    end
    $display("test correction done");
    // saturation at both ends, then an out-of-range slot
    wr(A_SYSC, 24'h000000);
    sg[gsel] = 24'hFFFFFF;
    wr({A_SGAIN5, gsel}, sg[gsel]);
    for (int k = 0; k < 2; k++)
    begin
      soff = k[0] ? OMAX : OMIN;
      wr(A_SOFF, soff);
      wr(A_RESULT_SLOT_SELECT, 24'h000000);
      conv(k[0] ? 24'h800000 : 24'h7FFFFF);
      rd({A_DATA5, 3'h0}, k[0] ? 24'h800000 : 24'h7FFFFF, "clip");
    end
    wr(A_RESULT_SLOT_SELECT, 24'h000008);
    wr(8'h1F, 24'h123456);  // results are read-only
    conv(24'h001000);
    rd({A_DATA5, 3'h7}, dat[7], "slot kept");
    $display("test saturation done");
    close_out();
  end
endmodule : tb
